// file: src/ocfq_pkg.sv
// Constants, encodings and timing for the overcurrent fault qualifier.
// Assumes a single 125 MHz device clock and an excursion code of 10 mV.
//
// How it works
// (RULE1) Offset trim is signed, reference left untouched
// (RULE2) Programmer keeps trim in 0-223, 288-511
// (RULE3) Threshold resets to the 2 V excursion code
// (RULE4) Fault only after continuous over-threshold mask time
// (RULE5) Mask codes 0-6 map 0..3.5 us, default 1
// (RULE6) Fault held at least the selected hold time
// (RULE7) Hold codes 0-7 map 0..5 ms, default 0
// (RULE8) Release sits 120 or 240 mV below threshold
// (RULE9) Ref mode: 0,1 input, 2 output, 3 both
// (RULE10) Combined mode drives ref yet allows overdrive
// (RULE11) Economy bit selects 15 mA or 7.5 mA drive
// (RULE12) Temperature gain slope is six-bit signed
// (RULE13) Gain slope adds nothing at 25 C
// (RULE14) Fault pin is open drain, active low
// (RULE15) Mask and hold counted in clocks, code 7 max

package ocfq_pkg;

    // ==========================================================
    // Clock
    // ==========================================================
    localparam int unsigned CLK_MHZ       = 125;  // Device clock rate
    localparam int unsigned CLK_PERIOD_NS = 8;    // Device clock period

    // ==========================================================
    // Field selects of the configuration load port
    // ==========================================================
    localparam logic [2:0] SEL_TRIM  = 3'h0;  // Offset trim
    localparam logic [2:0] SEL_THR   = 3'h1;  // Fault threshold
    localparam logic [2:0] SEL_MASK  = 3'h2;  // Mask time code
    localparam logic [2:0] SEL_HOLD  = 3'h3;  // Hold time code
    localparam logic [2:0] SEL_HYS   = 3'h4;  // Hysteresis double
    localparam logic [2:0] SEL_REF   = 3'h5;  // Reference pin mode
    localparam logic [2:0] SEL_ECO   = 3'h6;  // Economy drive
    localparam logic [2:0] SEL_SLOPE = 3'h7;  // Gain slope

    // ==========================================================
    // Analog scaling and reset values
    // ==========================================================
    localparam int unsigned EXC_LSB_MV   = 10;    // Excursion code step
    localparam int unsigned FACT_THR_MV  = 2000;  // Factory trip excursion
    localparam int unsigned HYS_MV       = 120;   // Normal hysteresis
    localparam int unsigned HYS_DBL_MV   = 240;   // Doubled hysteresis
    localparam logic [9:0]  HYS_CODE     = 10'(HYS_MV / EXC_LSB_MV);
    localparam logic [9:0]  HYS_DBL_CODE = 10'(HYS_DBL_MV / EXC_LSB_MV);
    localparam logic [8:0]  TRIM_RST     = 9'h000;
    localparam logic [8:0]  THR_RST      = 9'(FACT_THR_MV / EXC_LSB_MV);
    localparam logic [2:0]  MASK_RST     = 3'h1;
    localparam logic [2:0]  HOLD_RST     = 3'h0;
    localparam logic        HYS_RST      = 1'b0;
    localparam logic [1:0]  REF_RST      = 2'h3;
    localparam logic        ECO_RST      = 1'b0;
    localparam logic [5:0]  SLOPE_RST    = 6'h00;
    localparam logic [1:0]  REF_OUT_ONLY = 2'h2;  // Output only code
    localparam logic [1:0]  REF_BOTH     = 2'h3;  // Input/output code

    // Drive limit in half milliamps
    localparam logic [4:0]  DRIVE_FULL_HMA = 5'h1e;  // 15 mA
    localparam logic [4:0]  DRIVE_ECO_HMA  = 5'h0f;  // 7.5 mA
    localparam logic signed [8:0] TEMP_CENTER_C = 9'sd25;

    // ==========================================================
    // Mask times in ns, least times so counts round up
    // ==========================================================
    localparam int unsigned MASK1_NS = 500;
    localparam int unsigned MASK2_NS = 1000;
    localparam int unsigned MASK3_NS = 2000;
    localparam int unsigned MASK4_NS = 2500;
    localparam int unsigned MASK5_NS = 3000;
    localparam int unsigned MASK6_NS = 3500;

    // ==========================================================
    // Hold times in us; counts pass 4096 so top exposes them
    // ==========================================================
    localparam int unsigned HOLD1_US = 100;
    localparam int unsigned HOLD2_US = 250;
    localparam int unsigned HOLD3_US = 500;
    localparam int unsigned HOLD4_US = 1000;
    localparam int unsigned HOLD5_US = 2000;
    localparam int unsigned HOLD6_US = 3500;
    localparam int unsigned HOLD7_US = 5000;
    localparam int unsigned HOLD1_CYC = HOLD1_US * CLK_MHZ;
    localparam int unsigned HOLD2_CYC = HOLD2_US * CLK_MHZ;
    localparam int unsigned HOLD3_CYC = HOLD3_US * CLK_MHZ;
    localparam int unsigned HOLD4_CYC = HOLD4_US * CLK_MHZ;
    localparam int unsigned HOLD5_CYC = HOLD5_US * CLK_MHZ;
    localparam int unsigned HOLD6_CYC = HOLD6_US * CLK_MHZ;
    localparam int unsigned HOLD7_CYC = HOLD7_US * CLK_MHZ;

    // Qualifier states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MASK  = 2'b01,
        ST_FAULT = 2'b10
    } ocfq_state_type;

    // Least time in ns to whole clock cycles, rounded up
    function automatic logic [19:0] ocfq_ns_to_cyc(input int unsigned ns);
        ocfq_ns_to_cyc = 20'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : ocfq_ns_to_cyc

endpackage : ocfq_pkg

// file: src/ocfq_timer.sv
// Down counter used for the mask and hold intervals.
// Assumes the owner loads it on entry to the interval it times.
`timescale 1ns/1ps
`default_nettype none

module ocfq_timer (
    input  wire logic        mclk,     // Device clock
    input  wire logic        reset,    // Async reset, active high
    input  wire logic        load,     // Start a new interval
    input  wire logic [19:0] value,    // Cycles left after load
    output logic             expired   // Count has reached zero
);

    logic [19:0] count_reg;  // Remaining cycles

    // ==========================================================
    // Counter
    // ==========================================================
    // Load wins over the running decrement so a restart is exact
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_reg <= 20'h00000;
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != 20'h00000) begin
            count_reg <= count_reg - 20'h00001;
        end
    end

    assign expired = (count_reg == 20'h00000);

endmodule : ocfq_timer
`default_nettype wire

// file: src/ocfq_top.sv
// Overcurrent fault qualifier with its user configuration fields.
// Assumes excursion and temperature codes synchronous to mclk,
// and an external pull-up on the open-drain fault pin.
`timescale 1ns/1ps
`default_nettype none

module ocfq_top #(
    parameter int unsigned HOLD1_CYC = ocfq_pkg::HOLD1_CYC,  // 0.1 ms
    parameter int unsigned HOLD2_CYC = ocfq_pkg::HOLD2_CYC,  // 0.25 ms
    parameter int unsigned HOLD3_CYC = ocfq_pkg::HOLD3_CYC,  // 0.5 ms
    parameter int unsigned HOLD4_CYC = ocfq_pkg::HOLD4_CYC,  // 1 ms
    parameter int unsigned HOLD5_CYC = ocfq_pkg::HOLD5_CYC,  // 2 ms
    parameter int unsigned HOLD6_CYC = ocfq_pkg::HOLD6_CYC,  // 3.5 ms
    parameter int unsigned HOLD7_CYC = ocfq_pkg::HOLD7_CYC   // 5 ms
) (
    input  wire logic              mclk,          // Device clock
    input  wire logic              reset,         // Async reset, high
    input  wire logic              cfg_we,        // Field write strobe
    input  wire logic [2:0]        cfg_sel,       // Field written
    input  wire logic [8:0]        cfg_wdata,     // Field value, low bits
    input  wire logic [2:0]        cfg_rsel,      // Field read back
    output logic      [8:0]        cfg_rdata,     // Read back value
    input  wire logic signed [9:0] exc_i,         // Output minus ref
    input  wire logic signed [7:0] temp_c_i,      // Die temperature
    output logic                   fault_n_o,     // Fault pin level
    output logic                   fault_oe,      // Fault pin enable
    output logic                   fault_active,  // Fault state flag
    output logic signed [9:0]      qoffset_o,     // Zero-field shift
    output logic                   ref_drive_o,   // Ref driven inside
    output logic                   ref_sense_o,   // Ref pin sensed
    output logic      [4:0]        drive_hma_o,   // Drive limit 0.5 mA
    output logic signed [14:0]     gain_adj_o     // Gain change term
);

    // ==========================================================
    // Configuration registers
    // ==========================================================
    logic [8:0] trim_reg;   // Offset trim, signed
    logic [8:0] thr_reg;    // Fault threshold code
    logic [2:0] mask_reg;   // Mask time code
    logic [2:0] hold_reg;   // Hold time code
    logic       hys_reg;    // Hysteresis double
    logic [1:0] ref_reg;    // Reference pin mode
    logic       eco_reg;    // Economy drive
    logic [5:0] slope_reg;  // Gain slope, signed

    // Write decode
    wire we_trim  = cfg_we && (cfg_sel == ocfq_pkg::SEL_TRIM);
    wire we_thr   = cfg_we && (cfg_sel == ocfq_pkg::SEL_THR);
    wire we_mask  = cfg_we && (cfg_sel == ocfq_pkg::SEL_MASK);
    wire we_hold  = cfg_we && (cfg_sel == ocfq_pkg::SEL_HOLD);
    wire we_hys   = cfg_we && (cfg_sel == ocfq_pkg::SEL_HYS);
    wire we_ref   = cfg_we && (cfg_sel == ocfq_pkg::SEL_REF);
    wire we_eco   = cfg_we && (cfg_sel == ocfq_pkg::SEL_ECO);
    wire we_slope = cfg_we && (cfg_sel == ocfq_pkg::SEL_SLOPE);

    // Threshold and trim fields; threshold starts at the 2 V code
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trim_reg <= ocfq_pkg::TRIM_RST;
            thr_reg  <= ocfq_pkg::THR_RST;       // [RULE3]
        end else begin
            if (we_trim) begin
                trim_reg <= cfg_wdata;
            end
            if (we_thr) begin
                thr_reg <= cfg_wdata;            // [RULE3]
            end
        end
    end

    // Timing fields
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mask_reg <= ocfq_pkg::MASK_RST;      // [RULE5]
            hold_reg <= ocfq_pkg::HOLD_RST;      // [RULE7]
            hys_reg  <= ocfq_pkg::HYS_RST;       // [RULE8]
        end else begin
            if (we_mask) begin
                mask_reg <= cfg_wdata[2:0];
            end
            if (we_hold) begin
                hold_reg <= cfg_wdata[2:0];
            end
            if (we_hys) begin
                hys_reg <= cfg_wdata[0];
            end
        end
    end

    // Output stage fields
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ref_reg   <= ocfq_pkg::REF_RST;      // [RULE9]
            eco_reg   <= ocfq_pkg::ECO_RST;      // [RULE11]
            slope_reg <= ocfq_pkg::SLOPE_RST;
        end else begin
            if (we_ref) begin
                ref_reg <= cfg_wdata[1:0];
            end
            if (we_eco) begin
                eco_reg <= cfg_wdata[0];
            end
            if (we_slope) begin
                slope_reg <= cfg_wdata[5:0];
            end
        end
    end

    // Read back mux, narrow fields padded with zeros
    wire [8:0] rdata_next =
        (cfg_rsel == ocfq_pkg::SEL_TRIM) ? trim_reg :
        (cfg_rsel == ocfq_pkg::SEL_THR)  ? thr_reg :
        (cfg_rsel == ocfq_pkg::SEL_MASK) ? {6'h00, mask_reg} :
        (cfg_rsel == ocfq_pkg::SEL_HOLD) ? {6'h00, hold_reg} :
        (cfg_rsel == ocfq_pkg::SEL_HYS)  ? {8'h00, hys_reg} :
        (cfg_rsel == ocfq_pkg::SEL_REF)  ? {7'h00, ref_reg} :
        (cfg_rsel == ocfq_pkg::SEL_ECO)  ? {8'h00, eco_reg} :
        {3'h0, slope_reg};

    // ==========================================================
    // Comparator with hysteresis
    // ==========================================================
    // Magnitude of the swing; either direction trips the fault
    wire [9:0] exc_mag = exc_i[9] ? 10'(-exc_i) : 10'(exc_i);
    wire [9:0] thr_ext = {1'b0, thr_reg};
    wire [9:0] hys_cod = hys_reg ? ocfq_pkg::HYS_DBL_CODE
                                 : ocfq_pkg::HYS_CODE;
    // Release level clamps at zero for very low thresholds
    wire [9:0] rel_thr = (thr_ext > hys_cod) ? (thr_ext - hys_cod)
                                             : 10'h000;          // [RULE8]
    wire       over    = (exc_mag >= thr_ext);
    wire       release_ok = (exc_mag < rel_thr);                 // [RULE8]

    // ==========================================================
    // Interval decode
    // ==========================================================
    // Code 7 is not listed; it takes the longest mask
    wire [19:0] mask_cyc =
        (mask_reg == 3'h0) ? 20'h00000 :
        (mask_reg == 3'h1) ? ocfq_pkg::ocfq_ns_to_cyc(ocfq_pkg::MASK1_NS) :
        (mask_reg == 3'h2) ? ocfq_pkg::ocfq_ns_to_cyc(ocfq_pkg::MASK2_NS) :
        (mask_reg == 3'h3) ? ocfq_pkg::ocfq_ns_to_cyc(ocfq_pkg::MASK3_NS) :
        (mask_reg == 3'h4) ? ocfq_pkg::ocfq_ns_to_cyc(ocfq_pkg::MASK4_NS) :
        (mask_reg == 3'h5) ? ocfq_pkg::ocfq_ns_to_cyc(ocfq_pkg::MASK5_NS) :
        ocfq_pkg::ocfq_ns_to_cyc(ocfq_pkg::MASK6_NS);            // [RULE5] [RULE15]

    wire [19:0] hold_cyc =
        (hold_reg == 3'h0) ? 20'h00000 :
        (hold_reg == 3'h1) ? 20'(HOLD1_CYC) :
        (hold_reg == 3'h2) ? 20'(HOLD2_CYC) :
        (hold_reg == 3'h3) ? 20'(HOLD3_CYC) :
        (hold_reg == 3'h4) ? 20'(HOLD4_CYC) :
        (hold_reg == 3'h5) ? 20'(HOLD5_CYC) :
        (hold_reg == 3'h6) ? 20'(HOLD6_CYC) :
        20'(HOLD7_CYC);                                          // [RULE7] [RULE15]

    wire        mask_zero = (mask_cyc == 20'h00000);
    // The entry cycle counts as the first qualified sample
    wire [19:0] mask_load_val = mask_zero ? 20'h00000
                                          : (mask_cyc - 20'h00001);

    // ==========================================================
    // Qualifier state machine
    // ==========================================================
    ocfq_pkg::ocfq_state_type st_reg;   // Current state
    ocfq_pkg::ocfq_state_type st_next;  // Next state
    logic mask_load;                    // Start mask interval
    logic hold_load;                    // Start hold interval
    logic mask_exp;                     // Mask interval done
    logic hold_exp;                     // Hold interval done

    ocfq_timer u_mask_timer (
        .mclk    (mclk),
        .reset   (reset),
        .load    (mask_load),
        .value   (mask_load_val),
        .expired (mask_exp)
    );

    ocfq_timer u_hold_timer (
        .mclk    (mclk),
        .reset   (reset),
        .load    (hold_load),
        .value   (hold_cyc),
        .expired (hold_exp)
    );

    // Any dip below threshold during the mask restarts from idle
    always_comb begin
        st_next   = st_reg;
        mask_load = 1'b0;
        hold_load = 1'b0;
        case (st_reg)
            ocfq_pkg::ST_IDLE: begin
                if (over && mask_zero) begin
                    st_next   = ocfq_pkg::ST_FAULT;
                    hold_load = 1'b1;
                end else if (over) begin
                    st_next   = ocfq_pkg::ST_MASK;             // [RULE4]
                    mask_load = 1'b1;
                end
            end
            ocfq_pkg::ST_MASK: begin
                if (!over) begin
                    st_next = ocfq_pkg::ST_IDLE;               // [RULE4]
                end else if (mask_exp) begin
                    st_next   = ocfq_pkg::ST_FAULT;
                    hold_load = 1'b1;
                end
            end
            ocfq_pkg::ST_FAULT: begin
                // Needs both the hold time and a true release
                if (hold_exp && release_ok) begin
                    st_next = ocfq_pkg::ST_IDLE;               // [RULE6] [RULE8]
                end
            end
            default: begin
                st_next = ocfq_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_reg <= ocfq_pkg::ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Output stage decode
    // ==========================================================
    wire signed [9:0]  qoffset_next = 10'(signed'(trim_reg));    // [RULE1]
    wire               ref_drive_next = ref_reg[1];              // [RULE9] [RULE10]
    wire               ref_sense_next = (ref_reg != ocfq_pkg::REF_OUT_ONLY);
    wire [4:0]         drive_next = eco_reg ? ocfq_pkg::DRIVE_ECO_HMA
                                            : ocfq_pkg::DRIVE_FULL_HMA;  // [RULE11]
    wire signed [8:0]  temp_dt = 9'(temp_c_i) - ocfq_pkg::TEMP_CENTER_C;
    // Both factors widened first so the product is not cut to nine bits
    wire signed [14:0] gain_next = 15'(signed'(slope_reg)) * 15'(temp_dt);  // [RULE12] [RULE13]

    // All outputs leave from flops
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fault_n_o    <= 1'b0;
            fault_oe     <= 1'b0;
            fault_active <= 1'b0;
            cfg_rdata    <= 9'h000;
        end else begin
            fault_n_o    <= 1'b0;                              // [RULE14]
            fault_oe     <= (st_next == ocfq_pkg::ST_FAULT);   // [RULE14]
            fault_active <= (st_next == ocfq_pkg::ST_FAULT);
            cfg_rdata    <= rdata_next;
        end
    end

    // Analog control outputs; combined ref mode drives and senses
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            qoffset_o   <= 10'sh000;
            ref_drive_o <= 1'b1;
            ref_sense_o <= 1'b1;
            drive_hma_o <= ocfq_pkg::DRIVE_FULL_HMA;
            gain_adj_o  <= 15'sh0000;
        end else begin
            qoffset_o   <= qoffset_next;
            ref_drive_o <= ref_drive_next;
            ref_sense_o <= ref_sense_next;
            drive_hma_o <= drive_next;
            gain_adj_o  <= gain_next;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_trim_signed;
        @(posedge mclk) disable iff (reset)
        1'b1 |=> (qoffset_o == 10'(signed'($past(trim_reg))));
    endproperty
    a_trim_signed: assert property (p_trim_signed)  // [RULE1]
        else $error("offset shift not sign extended");

    property p_thr_reset;
        @(posedge mclk) disable iff (reset)
        $fell(reset) |-> (thr_reg == 9'h0c8);
    endproperty
    a_thr_reset: assert property (p_thr_reset)  // [RULE3]
        else $error("threshold not at factory code");

    property p_mask_cause;
        @(posedge mclk) disable iff (reset)
        $rose(fault_oe) |-> $past(over);
    endproperty
    a_mask_cause: assert property (p_mask_cause)  // [RULE4]
        else $error("fault rose without overcurrent");

    property p_mask_default;
        @(posedge mclk) disable iff (reset)
        (st_reg == ocfq_pkg::ST_IDLE && over && mask_reg == 3'h1)
        |=> (st_reg == ocfq_pkg::ST_MASK) && !fault_oe;
    endproperty
    a_mask_default: assert property (p_mask_default)  // [RULE5]
        else $error("default mask did not delay fault");

    property p_hold_keep;
        @(posedge mclk) disable iff (reset)
        (st_reg == ocfq_pkg::ST_FAULT && !hold_exp) |=> fault_oe;
    endproperty
    a_hold_keep: assert property (p_hold_keep)  // [RULE6]
        else $error("fault dropped inside hold time");

    property p_hold_zero;
        @(posedge mclk) disable iff (reset)
        (hold_reg == 3'h0 && !cfg_we && st_reg == ocfq_pkg::ST_MASK
         && over && mask_exp) ##1 release_ok
        |=> !fault_oe;
    endproperty
    a_hold_zero: assert property (p_hold_zero)  // [RULE7]
        else $error("zero hold kept the fault");

    property p_hys_band;
        @(posedge mclk) disable iff (reset)
        (st_reg == ocfq_pkg::ST_FAULT && !release_ok) |=> fault_oe;
    endproperty
    a_hys_band: assert property (p_hys_band)  // [RULE8]
        else $error("fault released inside hysteresis");

    property p_ref_out;
        @(posedge mclk) disable iff (reset)
        (ref_reg == 2'h2) |=> (ref_drive_o && !ref_sense_o);
    endproperty
    a_ref_out: assert property (p_ref_out)  // [RULE9]
        else $error("output only mode wrong");

    property p_ref_both;
        @(posedge mclk) disable iff (reset)
        (ref_reg == 2'h3) |=> (ref_drive_o && ref_sense_o);
    endproperty
    a_ref_both: assert property (p_ref_both)  // [RULE10]
        else $error("combined ref mode wrong");

    property p_eco;
        @(posedge mclk) disable iff (reset)
        eco_reg |=> (drive_hma_o == 5'h0f);
    endproperty
    a_eco: assert property (p_eco)  // [RULE11]
        else $error("economy drive limit wrong");

    property p_center;
        @(posedge mclk) disable iff (reset)
        (temp_c_i == 8'sd25) |=> (gain_adj_o == 15'sh0000);
    endproperty
    a_center: assert property (p_center)  // [RULE13]
        else $error("gain change at center temperature");

    property p_open_drain;
        @(posedge mclk) disable iff (reset)
        (fault_n_o == 1'b0) && (fault_oe == fault_active);
    endproperty
    a_open_drain: assert property (p_open_drain)  // [RULE14]
        else $error("fault pin driven high");

    property p_mask_max;
        @(posedge mclk) disable iff (reset)
        (mask_reg == 3'h7) |-> (mask_cyc == 20'h001b6);
    endproperty
    a_mask_max: assert property (p_mask_max)  // [RULE15]
        else $error("mask code seven not maximum");

endmodule : ocfq_top
`default_nettype wire

// file: verification/ocfq_ctrl_model.sv
// Controller model that watches the open-drain fault pin.
// Assumes a pull-up on the pin; the device can only sink it.
`timescale 1ns/1ps
`default_nettype none
module ocfq_ctrl_model (
    input  wire logic pin_n_o,  // Level offered by the device
    input  wire logic pin_oe,   // Device sinking the pin
    output logic      pin_seen  // Level the controller reads
);
    // Pull-up wins whenever the device lets go, so idle reads high
    assign pin_seen = pin_oe ? pin_n_o : 1'b1;
endmodule : ocfq_ctrl_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the overcurrent fault qualifier.
// Assumes short counts for the hold codes that the run selects.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic              mclk = 0, reset = 1, we = 0, pin, oe, act, n_o, rdrv, rsen;  // Controls, pin
    logic [2:0]        sel = 0, rsel = 0;   // Field selects
    logic [8:0]        wd = 0, rd;          // Field data
    logic signed [9:0] exc = 0, qoff;       // Excursion, offset shift
    logic signed [7:0] temp = 8'sd25;       // Die temperature
    logic [4:0]        hma;                 // Drive limit
    logic signed [14:0] gadj;               // Gain change term
    int                err_total = 0, checked = 0, n;
    // ==========================================================
    // Clock, design and pin partner
    initial forever #4 mclk = ~mclk;
    ocfq_top #(.HOLD1_CYC(10), .HOLD2_CYC(20), .HOLD3_CYC(30), .HOLD4_CYC(40),
        .HOLD7_CYC(70)) dut_u (.mclk(mclk), .reset(reset), .cfg_we(we), .cfg_sel(sel),
        .cfg_wdata(wd), .cfg_rsel(rsel), .cfg_rdata(rd), .exc_i(exc), .temp_c_i(temp), .fault_n_o(n_o),
        .fault_oe(oe), .fault_active(act), .qoffset_o(qoff), .ref_drive_o(rdrv), .ref_sense_o(rsen),
        .drive_hma_o(hma), .gain_adj_o(gadj));
    ocfq_ctrl_model ctl_u (.pin_n_o(n_o), .pin_oe(oe), .pin_seen(pin));
    // ==========================================================
    // Shared tasks; inputs move only on the falling edge
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc
    task automatic wr(input logic [2:0] s, input logic [8:0] d);
        @(negedge mclk);
        we = 1; sel = s; wd = d;
        @(negedge mclk);
        we = 0;
    endtask : wr
    // Bounded wait for the fault flag to reach a level
    task automatic wait_act(input logic lvl, input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (act !== lvl && n < lim);
    endtask : wait_act
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [8:0] rv[8] = '{9'h000, 9'h0c8, 9'h001, 9'h000, 9'h000, 9'h003, 9'h000, 9'h000};
        for (int i = 0; i < 8; i++) begin
            rsel = 3'(i);
            cyc(2);
            chk(15'(rd), 15'(rv[i]));
        end
        chk(15'({hma, rdrv, rsen, pin}), 15'hf7);
        $display("reset values done");
    endtask : t_reset
    // Mask codes 0,1,3,7: flag rises one edge after the mask count
    task automatic t_mask;
        int mc[4] = '{0, 1, 3, 7};
        int me[4] = '{1, 64, 251, 439};
        for (int i = 0; i < 4; i++) begin
            wr(3'h2, 9'(mc[i]));
            exc = 10'sd200;
            wait_act(1'b1, 500);
            chk(15'(n), 15'(me[i]));
            chk(15'(pin), 15'h0);
            exc = 10'sd0;
            wait_act(1'b0, 10);
        end
        $display("mask times done");
    endtask : t_mask
    // Hold codes 2 and 7 keep the flag 20 and 70 cycles plus the release edge;
    // hysteresis band 12 then 24 codes
    task automatic t_hold;
        int hc[2] = '{2, 7};
        int he[2] = '{21, 71};
        wr(3'h2, 9'h0);
        for (int i = 0; i < 2; i++) begin
            wr(3'h3, 9'(hc[i]));
            exc = -10'sd200;
            wait_act(1'b1, 5);
            exc = 10'sd0;
            wait_act(1'b0, 80);
            chk(15'(n), 15'(he[i]));
        end
        wr(3'h3, 9'h0);
        exc = 10'sd200;
        cyc(3);
        exc = 10'sd190;
        cyc(40);
        chk(15'(act), 15'h1);
        exc = 10'sd187;
        cyc(3);
        chk(15'(act), 15'h0);
        wr(3'h4, 9'h1);
        exc = -10'sd200;
        cyc(3);
        exc = -10'sd176;
        cyc(30);
        chk(15'(act), 15'h1);
        exc = -10'sd175;
        cyc(3);
        chk(15'(act), 15'h0);
        $display("hold and hysteresis done");
    endtask : t_hold
    // Field decodes: signed trim, reference modes, economy, slope
    task automatic t_decode;
        logic [1:0] rx[4] = '{2'h1, 2'h1, 2'h2, 2'h3};
        wr(3'h0, 9'h1ff);
        wr(3'h6, 9'h1);
        wr(3'h7, 9'h020);
        cyc(2);
        chk(15'(qoff), 15'h7fff);
        chk(15'(hma), 15'h0f);
        chk(gadj, 15'h0);
        temp = 8'sd127;
        cyc(2);
        chk(gadj, 15'h7340);
        for (int i = 0; i < 4; i++) begin
            wr(3'h5, 9'(i));
            cyc(2);
            chk(15'({rdrv, rsen}), 15'(rx[i]));
        end
        $display("decodes done");
    endtask : t_decode
    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic finish_test;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        cyc(5);
        reset = 0;
        t_reset;
        t_mask;
        t_hold;
        t_decode;
        finish_test;
    end
    // Tests need about 1000 cycles; a hang stops well beyond that
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        finish_test;
    end
endmodule : tb_top
`default_nettype wire
